// ===== bmp_defs.vh
// Purpose: shared constants of the parity memory board with its control/status register
// Assumes: 40 MHz system clock, 22-bit byte address on the backplane side
// Notes: offsets are AHB byte addresses of the software register window
`ifndef BMP_DEFS_VH
`define BMP_DEFS_VH

// software register window (AHB byte offsets)
`define BMP_OFS_CSR 12'h000
`define BMP_OFS_ISTAT 12'h004
`define BMP_OFS_IMASK 12'h008
`define BMP_OFS_CFG 12'h00c

// control/status register layout
`define BMP_CSR_ERR 15
`define BMP_CSR_EADR_HI 11
`define BMP_CSR_EADR_LO 5
`define BMP_CSR_FORCE 2
`define BMP_CSR_WARN_EN 0
`define BMP_CSR_WMASK 16'h8005
`define BMP_CSR_RST 16'h0000
// failing address bits copied into the error-address field
`define BMP_EADR_SRC_HI 17
`define BMP_EADR_SRC_LO 11

// configuration register layout
`define BMP_CFG_BASE_HI 4
`define BMP_CFG_BASE_LO 0
`define BMP_CFG_IOEX 8
`define BMP_CFG_SEL_HI 15
`define BMP_CFG_SEL_LO 12
`define BMP_CFG_WMASK 32'h0000_f11f
`define BMP_CFG_RST 32'h0000_0100

// interrupt status / mask bits
`define BMP_INT_PERR 0
`define BMP_INT_CSRWR 1
`define BMP_INT_W 2

// backplane decode: status register window starts at octal 17772100
`define BMP_CSR_TAG 17'h1ffa2
`define BMP_IOPAGE_TAG 10'h3ff
`define BMP_BANK_LSB 17
`define BMP_MEM_AW 16

// refresh timing
`define BMP_CLK_NS 25
`define BMP_REF_NS 12000
`define BMP_REF_MARGIN 4
`define BMP_REF_CYC ((`BMP_REF_NS / `BMP_CLK_NS) - `BMP_REF_MARGIN)

`endif

// ===== bmp_mem.v
// Purpose: 18-bit word storage array with per-byte lane writes
// Assumes: one access per clock, read data registered
// Notes: each lane keeps a data byte and its parity bit together
`timescale 1ns/1ps
`default_nettype none
module bmp_mem (
    input wire clk,
    input wire we_lo,
    input wire we_hi,
    input wire [15:0] addr,
    input wire [17:0] wdata,
    output wire [17:0] rdata
);
    wire [1:0] we;
    wire [17:0] rd_w;

    assign we = {we_hi, we_lo};
    assign rdata = rd_w;

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : lane
            reg [8:0] arr [0:65535];
            reg [8:0] q_reg;
            always @(posedge clk) begin
                if (we[i]) begin
                    arr[addr] <= {wdata[16+i], wdata[8*i+7:8*i]};
                end
                q_reg <= arr[addr];
            end
            assign rd_w[8*i+7:8*i] = q_reg[7:0];
            assign rd_w[16+i] = q_reg[8];
        end
    endgenerate
endmodule
`default_nettype wire

// ===== bmp_csr_top.v
// Purpose: parity generation/check, status register, decode and refresh of a memory board
// Assumes: backplane requests are synchronous one-cycle pulses taken while BUS_RDY is high
// Notes: unmapped backplane addresses get no reply, the master times out as on the real bus
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`include "bmp_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module bmp_csr_top (
    input wire CLK_SYS,
    input wire ARST_N,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output reg HREADYOUT,
    output reg [31:0] HRDATA,
    output reg HRESP,
    input wire BUS_REQ,
    input wire BUS_WRITE,
    input wire BUS_BYTE,
    input wire [21:0] BUS_ADDR,
    input wire [15:0] BUS_WDATA,
    output reg BUS_RDY,
    output reg BUS_REPLY,
    output reg [15:0] BUS_RDATA,
    output reg [1:0] BUS_WARN,
    output reg ERR_LED,
    output reg DRAM_REFRESH,
    output reg IRQ
);
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_CHK = 3'b010;
    localparam [2:0] S_REF = 3'b100;
    // the reload is cut to the nine-bit counter on purpose, 476 fits easily
    localparam [31:0] REF_CYC_W = `BMP_REF_CYC;
    localparam [8:0] REF_LOAD = REF_CYC_W[8:0];
    localparam [15:0] CSR_WMASK = `BMP_CSR_WMASK;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [15:0] csr_reg;
    reg [15:0] csr_next;
    reg [31:0] cfg_reg;
    reg [31:0] cfg_next;
    reg [1:0] istat_reg;
    reg [1:0] istat_next;
    reg [1:0] imask_reg;
    reg [1:0] imask_next;
    reg [21:0] addr_reg;
    reg [8:0] ref_cnt_reg;
    reg [8:0] ref_cnt_next;
    reg ref_pend_reg;
    reg ref_pend_next;
    reg ahb_dph_reg;
    reg ahb_wr_reg;
    reg [11:0] ahb_addr_reg;
    reg [31:0] ahb_rval;
    reg [15:0] rdata_next;
    reg reply_next;
    reg [1:0] warn_next;

    wire bus_take;
    wire csr_hit;
    wire io_hit;
    wire mem_hit;
    wire lane_lo;
    wire lane_hi;
    wire mem_wr;
    wire mem_rd;
    wire force_bad;
    wire [1:0] par_w;
    wire mem_we_lo;
    wire mem_we_hi;
    wire [17:0] mem_wdata;
    wire [17:0] mem_rdata;
    wire [1:0] perr_w;
    wire perr_evt;
    wire csr_bus_wr;
    wire ahb_take;
    wire ahb_wr_dph;
    wire ahb_rd_dph;
    wire ahb_wr_csr;
    wire ahb_rd_istat;
    wire ahb_wr_imask;
    wire ahb_wr_cfg;
    wire ref_tick;
    wire [4:0] cfg_base;
    wire [3:0] cfg_sel;
    wire cfg_ioex;

    assign cfg_base = cfg_reg[`BMP_CFG_BASE_HI:`BMP_CFG_BASE_LO];
    assign cfg_sel = cfg_reg[`BMP_CFG_SEL_HI:`BMP_CFG_SEL_LO];
    assign cfg_ioex = cfg_reg[`BMP_CFG_IOEX];

    // backplane decode
    assign bus_take = BUS_REQ & BUS_RDY;
    assign csr_hit = (BUS_ADDR[21:5] == `BMP_CSR_TAG) && (BUS_ADDR[4:1] == cfg_sel);
    assign io_hit = cfg_ioex && (BUS_ADDR[21:12] == `BMP_IOPAGE_TAG);
    // the status register wins if software leaves the I/O page open over it
    assign mem_hit = (BUS_ADDR[21:`BMP_BANK_LSB] == cfg_base) & ~io_hit & ~csr_hit;
    assign mem_wr = bus_take & mem_hit & BUS_WRITE;
    assign mem_rd = bus_take & mem_hit & ~BUS_WRITE;
    // an address outside every window gets no reply at all, the master times out
    assign csr_bus_wr = bus_take & csr_hit & BUS_WRITE;

    // byte writes land on the lane picked by the low address bit
    assign lane_lo = ~BUS_BYTE | ~BUS_ADDR[0];
    assign lane_hi = ~BUS_BYTE | BUS_ADDR[0];
    assign mem_we_lo = mem_wr & lane_lo;
    assign mem_we_hi = mem_wr & lane_hi;

    // the force bit flips both lanes; a byte write stores only its own lane,
    // so the other byte of the word keeps its good parity
    assign force_bad = csr_reg[`BMP_CSR_FORCE];
    assign mem_wdata = {par_w, BUS_WDATA};

    // contents survive reset: a word read before any write has unknown parity
    bmp_mem u_mem (
        .clk(CLK_SYS),
        .we_lo(mem_we_lo),
        .we_hi(mem_we_hi),
        .addr(BUS_ADDR[`BMP_MEM_AW:1]),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // one odd-parity generator and one checker per byte lane
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : par_lane
            assign par_w[g] = (~^BUS_WDATA[8*g+7:8*g]) ^ force_bad;
            // the stored bit disagrees with what the fetched byte implies
            assign perr_w[g] = (~^mem_rdata[8*g+7:8*g]) != mem_rdata[16+g];
        end
    endgenerate

    // whole word is checked, a byte read still trusts neither lane blindly
    assign perr_evt = state_reg[1] & (|perr_w);

    // refresh timer; margin covers a read in flight when the tick lands
    assign ref_tick = (ref_cnt_reg == 9'h000);

    always @* begin
        ref_cnt_next = ref_tick ? (REF_LOAD - 9'h001) : (ref_cnt_reg - 9'h001);
        ref_pend_next = ref_pend_reg;
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (ref_pend_reg) begin
                    state_next = S_REF;
                    ref_pend_next = 1'b0;
                end else if (mem_rd) begin
                    state_next = S_CHK;
                end
            end
            S_CHK: begin
                // the fetched word stands only in this cycle
                state_next = S_IDLE;
            end
            S_REF: begin
                // one cycle keeps the array free for the refresh strobe
                state_next = S_IDLE;
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
        if (ref_tick) begin
            ref_pend_next = 1'b1;
        end
    end

    // backplane answer
    always @* begin
        rdata_next = BUS_RDATA;
        reply_next = 1'b0;
        warn_next = 2'b00;
        if (state_reg == S_CHK) begin
            rdata_next = mem_rdata[15:0];
            reply_next = 1'b1;
            if (perr_evt && csr_reg[`BMP_CSR_WARN_EN]) begin
                warn_next = 2'b11;
            end
        end else if (bus_take && csr_hit) begin
            // the register answers one cycle after the request is taken
            rdata_next = csr_reg;
            reply_next = 1'b1;
        end else if (mem_wr) begin
            reply_next = 1'b1;
        end
    end

    // software side
    assign ahb_take = HSEL & HREADY & HTRANS[1];
    // register effects happen in the data phase, when HWDATA is on the bus
    assign ahb_wr_dph = ahb_dph_reg & ahb_wr_reg;
    assign ahb_rd_dph = ahb_dph_reg & ~ahb_wr_reg;
    assign ahb_wr_csr = ahb_wr_dph & (ahb_addr_reg == `BMP_OFS_CSR);
    assign ahb_rd_istat = ahb_rd_dph & (ahb_addr_reg == `BMP_OFS_ISTAT);
    assign ahb_wr_imask = ahb_wr_dph & (ahb_addr_reg == `BMP_OFS_IMASK);
    assign ahb_wr_cfg = ahb_wr_dph & (ahb_addr_reg == `BMP_OFS_CFG);

    always @* begin
        case (ahb_addr_reg)
            `BMP_OFS_CSR: ahb_rval = {16'h0000, csr_reg};
            `BMP_OFS_ISTAT: ahb_rval = {30'h00000000, istat_reg};
            `BMP_OFS_IMASK: ahb_rval = {30'h00000000, imask_reg};
            `BMP_OFS_CFG: ahb_rval = cfg_reg;
            default: ahb_rval = 32'h0000_0000;
        endcase
    end

    // status register: writes first, hardware error set last so it wins
    always @* begin
        csr_next = csr_reg;
        if (csr_bus_wr && lane_lo) begin
            csr_next[7:0] = (csr_next[7:0] & ~CSR_WMASK[7:0]) | (BUS_WDATA[7:0] & CSR_WMASK[7:0]);
        end
        // bit 15 also takes a 1 from software, which lights the indicator as a lamp test
        if (csr_bus_wr && lane_hi) begin
            csr_next[15:8] = (csr_next[15:8] & ~CSR_WMASK[15:8])
                | (BUS_WDATA[15:8] & CSR_WMASK[15:8]);
        end
        if (ahb_wr_csr) begin
            csr_next = (csr_next & ~CSR_WMASK) | (HWDATA[15:0] & CSR_WMASK);
        end
        if (perr_evt) begin
            csr_next[`BMP_CSR_ERR] = 1'b1;
            csr_next[`BMP_CSR_EADR_HI:`BMP_CSR_EADR_LO] =
                addr_reg[`BMP_EADR_SRC_HI:`BMP_EADR_SRC_LO];
        end
    end

    // sticky events: a read clears, a set in the same cycle survives
    always @* begin
        istat_next = istat_reg;
        if (ahb_rd_istat) begin
            istat_next = 2'b00;
        end
        if (perr_evt) begin
            istat_next[`BMP_INT_PERR] = 1'b1;
        end
        if (csr_bus_wr) begin
            istat_next[`BMP_INT_CSRWR] = 1'b1;
        end
    end

    always @* begin
        imask_next = imask_reg;
        cfg_next = cfg_reg;
        if (ahb_wr_imask) begin
            imask_next = HWDATA[`BMP_INT_W-1:0];
        end
        if (ahb_wr_cfg) begin
            // only the defined fields stick, the rest keep reading zero
            cfg_next = HWDATA & `BMP_CFG_WMASK;
        end
    end

    always @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= S_IDLE;
            csr_reg <= `BMP_CSR_RST;
            cfg_reg <= `BMP_CFG_RST;
            istat_reg <= 2'b00;
            imask_reg <= 2'b00;
            addr_reg <= 22'h000000;
        end else begin
            state_reg <= state_next;
            csr_reg <= csr_next;
            cfg_reg <= cfg_next;
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            // kept for the error-address field of a read still being checked
            if (bus_take) begin
                addr_reg <= BUS_ADDR;
            end
        end
    end

    // refresh bookkeeping runs whatever the buses are doing
    always @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            // zero makes a refresh owed right after reset, before any request
            ref_cnt_reg <= 9'h000;
            ref_pend_reg <= 1'b0;
        end else begin
            ref_cnt_reg <= ref_cnt_next;
            ref_pend_reg <= ref_pend_next;
        end
    end

    // backplane pins and indicators, each straight from a flip-flop
    always @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            BUS_RDY <= 1'b0;
            BUS_REPLY <= 1'b0;
            BUS_RDATA <= 16'h0000;
            BUS_WARN <= 2'b00;
            ERR_LED <= 1'b0;
            DRAM_REFRESH <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            // no new request while a refresh is owed or a read is being checked
            BUS_RDY <= (state_next == S_IDLE) & ~ref_pend_next;
            BUS_REPLY <= reply_next;
            BUS_RDATA <= rdata_next;
            BUS_WARN <= warn_next;
            ERR_LED <= csr_next[`BMP_CSR_ERR];
            DRAM_REFRESH <= (state_next == S_REF);
            IRQ <= |(istat_next & imask_next);
        end
    end

    // AHB-Lite slave: every transfer takes one wait state, answer always OKAY
    always @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            ahb_dph_reg <= 1'b0;
            ahb_wr_reg <= 1'b0;
            ahb_addr_reg <= 12'h000;
            HREADYOUT <= 1'b1;
            HRDATA <= 32'h0000_0000;
            HRESP <= 1'b0;
        end else begin
            HRESP <= 1'b0;
            if (ahb_dph_reg) begin
                // an unmapped offset reads zero and still ends with OKAY
                ahb_dph_reg <= 1'b0;
                HREADYOUT <= 1'b1;
                if (!ahb_wr_reg) begin
                    HRDATA <= ahb_rval;
                end
            end else if (ahb_take) begin
                ahb_dph_reg <= 1'b1;
                ahb_wr_reg <= HWRITE;
                ahb_addr_reg <= {HADDR[11:2], 2'b00};
                HREADYOUT <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== bmp_csr_asserts.sv
// Purpose: port checks of the parity memory board
// Assumes: one clock domain, ARST_N active low
// Notes: refresh gap bound 480 cycles, 12.0 us at 25 ns
`timescale 1ns/1ps
`default_nettype none
module bmp_csr_asserts (
    input wire CLK_SYS,
    input wire ARST_N,
    input wire HSEL,
    input wire [1:0] HTRANS,
    input wire HREADY,
    input wire HREADYOUT,
    input wire HRESP,
    input wire BUS_REQ,
    input wire BUS_WRITE,
    input wire BUS_RDY,
    input wire BUS_REPLY,
    input wire [1:0] BUS_WARN,
    input wire ERR_LED,
    input wire DRAM_REFRESH
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    logic [9:0] gap_reg;
    always @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) gap_reg <= 10'h000;
        else gap_reg <= DRAM_REFRESH ? 10'h000 : gap_reg + 10'h001;
    end
    sequence s_wait; !HREADYOUT ##1 HREADYOUT; endsequence
    sequence s_warn; (BUS_WARN == 2'b11) ##1 (BUS_WARN == 2'b00); endsequence
    sequence s_rd2; $past(BUS_REQ && BUS_RDY && !BUS_WRITE, 2); endsequence
    property p_ahb_wait; HSEL && HREADY && HTRANS[1] |=> s_wait; endproperty
    a_ahb_wait: assert property (p_ahb_wait) else $error("ahb wait wrong");
    property p_okay; !HRESP; endproperty
    a_okay: assert property (p_okay) else $error("ahb resp not okay");
    property p_warn_src; BUS_WARN != 2'b00 |-> (BUS_REPLY && ERR_LED) and s_rd2; endproperty
    a_warn_src: assert property (p_warn_src) else $error("warn w/o read");
    property p_warn_len; BUS_WARN != 2'b00 |-> s_warn; endproperty
    a_warn_len: assert property (p_warn_len) else $error("warn shape wrong");
    property p_led_set; $rose(ERR_LED) |-> BUS_REPLY and s_rd2; endproperty
    a_led_set: assert property (p_led_set) else $error("led w/o read");
    property p_reply; BUS_REPLY |-> $past(BUS_REQ && BUS_RDY) or s_rd2; endproperty
    a_reply: assert property (p_reply) else $error("reply w/o request");
    property p_ref_gap; gap_reg < 10'h1e0; endproperty
    a_ref_gap: assert property (p_ref_gap) else $error("refresh late");
    property p_ref_busy; DRAM_REFRESH |-> !BUS_RDY ##1 !DRAM_REFRESH; endproperty
    a_ref_busy: assert property (p_ref_busy) else $error("refresh shape");
endmodule
`default_nettype wire

// ===== bmp_bp_master.sv
// Purpose: backplane master model for the parity memory board
// Assumes: a request counts at the edge where BUS_RDY is high
// Notes: lines are scrambled once taken; 8 edges without reply means no decode
`timescale 1ns/1ps
`default_nettype none
module bmp_bp_master (
    input wire CLK_SYS,
    input wire BUS_RDY,
    input wire BUS_REPLY,
    input wire [15:0] BUS_RDATA,
    input wire [1:0] BUS_WARN,
    output logic BUS_REQ,
    output logic BUS_WRITE,
    output logic BUS_BYTE,
    output logic [21:0] BUS_ADDR,
    output logic [15:0] BUS_WDATA
);
    initial {BUS_REQ, BUS_WRITE, BUS_BYTE, BUS_ADDR, BUS_WDATA} = '0;
    task automatic xfer(input logic w, b, input logic [21:0] a, input logic [15:0] d,
                        output logic ok, output logic [15:0] rd, output logic [1:0] wn);
        ok = 1'b0;
        rd = 16'h0000;
        wn = 2'b00;
        @(posedge CLK_SYS);
        BUS_REQ <= 1'b1;
        BUS_WRITE <= w;
        BUS_BYTE <= b;
        BUS_ADDR <= a;
        BUS_WDATA <= d;
        do @(posedge CLK_SYS); while (!BUS_RDY);
        BUS_REQ <= 1'b0;
        BUS_ADDR <= ~a;
        BUS_WDATA <= ~d;
        repeat (8) begin
            @(posedge CLK_SYS);
            if (BUS_REPLY && !ok) begin
                ok = 1'b1;
                rd = BUS_RDATA;
                wn = BUS_WARN;
            end
        end
    endtask
endmodule
`default_nettype wire

// ===== bmp_csr_top_tb.sv
// Purpose: self-checking bench of the parity memory board
// Assumes: AHB and backplane masters move after rising edges
// Notes: model keeps words and bad-parity lanes by array index
`include "bmp_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module bmp_csr_top_tb;
    logic CLK_SYS, ARST_N, HSEL, HWRITE;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [31:0] HADDR, HWDATA, r;
    wire HREADYOUT, HRESP, BUS_REQ, BUS_WRITE, BUS_BYTE, BUS_RDY, BUS_REPLY;
    wire ERR_LED, DRAM_REFRESH, IRQ;
    wire [1:0] BUS_WARN;
    wire [15:0] BUS_WDATA, BUS_RDATA;
    wire [21:0] BUS_ADDR;
    wire [31:0] HRDATA;
    wire HREADY = HREADYOUT;
    int n_errors = 0, checks = 0, seed = 9508, mcsr = 0, mist = 0, sel, i;
    int mem[int], bad[int], ad[6];
    logic ok;
    logic [15:0] rd;
    logic [1:0] wn;
    bmp_csr_top bmp_csr_top_inst (.*);
    bmp_bp_master bmp_bp_master_inst (.*);
    task automatic chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h want=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        HTRANS <= 2'b10;
        HADDR <= {20'h00000, a};
        HWRITE <= w;
        do @(posedge CLK_SYS); while (!HREADY);
        HTRANS <= 2'b00;
        HWDATA <= d;
        do @(posedge CLK_SYS); while (!HREADY);
        r = HRDATA;
    endtask
    task automatic csr(input int v);
        ahb(1'b1, `BMP_OFS_CSR, v);
        mcsr = (v & 'h8005) | (mcsr & 'h0fe0);
    endtask
    task automatic bw(input logic b, input int a, input logic [15:0] d);
        int w, l, m;
        w = (a >> 1) & 'hffff;
        l = !b ? 3 : a[0] ? 2 : 1;
        m = (l & 1 ? 'h00ff : 0) | (l & 2 ? 'hff00 : 0);
        bmp_bp_master_inst.xfer(1'b1, b, a, d, ok, rd, wn);
        chk(ok, 1);
        mem[w] = (mem[w] & ~m) | (d & m);
        bad[w] = mcsr[2] ? bad[w] | l : bad[w] & ~l;
    endtask
    task automatic br(input int a);
        int w;
        w = (a >> 1) & 'hffff;
        bmp_bp_master_inst.xfer(1'b0, 1'b0, a, 16'h0000, ok, rd, wn);
        chk(ok, 1);
        chk(rd, mem[w]);
        chk(wn, bad[w] && mcsr[0] ? 3 : 0);
        if (bad[w]) begin
            mcsr = (mcsr & ~'h0fe0) | 'h8000 | ((a >> 11) & 'h7f) << 5;
            mist = mist | 1;
        end
        chk(ERR_LED, mcsr[15]);
        chk(IRQ, mist & 1);
    endtask
    initial begin
        CLK_SYS = 1'b0;
        forever #12.5 CLK_SYS = ~CLK_SYS;
    end
    initial begin
        #125000;
        n_errors++;
        final_report();
    end
    initial begin
        {ARST_N, HWRITE, HTRANS, HADDR, HWDATA} = '0;
        HSEL = 1'b1;
        HSIZE = 3'b010;
        repeat (2) @(posedge CLK_SYS);
        @(negedge CLK_SYS) ARST_N <= 1'b1;
        chk(BUS_RDY, 0);
        ahb(1'b0, `BMP_OFS_CFG, 0);
        chk(r, `BMP_CFG_RST);
        ahb(1'b0, 12'h010, 0);
        chk(r, 0);
        sel = $random(seed) & 15;
        ahb(1'b1, `BMP_OFS_CFG, sel << 12 | 'h103);
        ahb(1'b1, `BMP_OFS_IMASK, 1);
        csr(1);
        for (i = 0; i < 6; i++) begin
            ad[i] = 'h060000 | $random(seed) & 'h1fffe;
            bw(1'b0, ad[i], $random(seed));
        end
        bw(1'b1, ad[0] | 1, $random(seed));
        bw(1'b1, ad[1], $random(seed));
        for (i = 0; i < 6; i++) br(ad[i]);
        csr(5);
        bw(1'b1, ad[2] | 1, $random(seed));
        csr(1);
        br(ad[2]);
        ahb(1'b0, `BMP_OFS_CSR, 0);
        chk(r, mcsr);
        csr(4);
        bw(1'b0, ad[3], $random(seed));
        csr(0);
        br(ad[3]);
        csr(0);
        repeat (2) @(posedge CLK_SYS);
        chk(ERR_LED, 0);
        ahb(1'b0, `BMP_OFS_ISTAT, 0);
        chk(r, mist);
        mist = 0;
        bmp_bp_master_inst.xfer(1'b1, 1'b0, 'h3ff440 + 2 * sel, 1, ok, rd, wn);
        chk(IRQ, 0);
        mcsr = mcsr & 'h0fe0 | 1;
        bmp_bp_master_inst.xfer(1'b0, 1'b0, 'h3ff440 + 2 * sel, 0, ok, rd, wn);
        chk(rd, mcsr);
        ahb(1'b0, `BMP_OFS_ISTAT, 0);
        chk(r, 2);
        bmp_bp_master_inst.xfer(1'b0, 1'b0, 'h3ff440 + 2 * (sel + 1 & 15), 0, ok, rd, wn);
        chk(ok, 0);
        bmp_bp_master_inst.xfer(1'b0, 1'b0, 'h080000, 0, ok, rd, wn);
        chk(ok, 0);
        ahb(1'b1, `BMP_OFS_CFG, sel << 12 | 'h1f);
        bw(1'b0, 'h3ff000, $random(seed));
        br('h3ff000);
        ahb(1'b1, `BMP_OFS_CFG, sel << 12 | 'h11f);
        bmp_bp_master_inst.xfer(1'b0, 1'b0, 'h3ff000, 0, ok, rd, wn);
        chk(ok, 0);
        repeat (1000) @(posedge CLK_SYS);
        final_report();
    end
endmodule
bind bmp_csr_top bmp_csr_asserts bmp_csr_asserts_inst (.*);
`default_nettype wire
